// file: logic/mps_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
module mps_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic in_valid, // write side valid
   output logic in_ready, // write side ready
   input wire logic [WIDTH-1:0] in_data, // write data
   output logic out_valid, // read side valid
   input wire logic out_ready, // read side ready
   output logic [WIDTH-1:0] out_data // read data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic full;
   logic empty;

   // extra pointer bit tells full from empty
   assign empty = (wr_q == rd_q);
   assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_q[AW-1:0]];

   always_ff @(posedge clk_sys) begin
      if (in_valid && !full) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (in_valid && !full) begin
            wr_q <= wr_q + 1'b1;
         end
         if (out_ready && !empty) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   property p_no_overflow;
      @(posedge clk_sys) disable iff (!rst_n)
         full |=> wr_q == $past(wr_q);
   endproperty
   a_no_overflow: assert property (p_no_overflow)
      else $error("fifo write pointer moved while full");
endmodule : mps_fifo

// file: logic/mps_mac_ctrl.sv
// pause flow control, long-frame and receive statistics slice of a 100 Mb/s mac
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
module mps_mac_ctrl
   import mps_pkg::*;
#(
   parameter logic [47:0] STATION_ADDR = 48'h0200_0000_0001, // arbitrary value
   parameter int FIFO_DEPTH = 32
) (
   input wire logic clk_sys, // 250 MHz system clock
   input wire logic nrst, // asynchronous reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic tx_in_valid, // frame byte from client
   output logic tx_in_ready, // fifo can take a byte
   input wire logic [7:0] tx_in_data, // client frame byte
   input wire logic tx_in_last, // last byte of client frame
   output logic tx_out_valid, // byte toward the phy side
   input wire logic tx_out_ready, // phy side takes byte
   output logic [7:0] tx_out_data, // byte toward the phy side
   output logic tx_out_last, // last byte of frame
   input wire logic rx_frame_done, // one pulse per received frame
   input wire logic rx_pause_valid, // received pause frame decoded
   input wire logic [15:0] rx_pause_quanta, // its pause time
   output logic tx_paused // transmitter held by partner
);
   // --------------------------------------------------------------
   // reset release
   // --------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // --------------------------------------------------------------
   // register state
   // --------------------------------------------------------------
   logic [15:0] quanta_q;
   logic honor_q;
   logic busy_q;
   logic [10:0] limit_q;
   logic stats_rsvd_q;
   logic [31:0] rsvd_a_q;
   logic [31:0] rsvd_b_q;
   logic [31:0] rx_count_q;
   logic [31:0] long_count_q;
   logic wr_en;
   logic setup;
   logic mapped;
   logic [31:0] rd_val;
   logic [31:0] rd_val_q;
   logic busy_done;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   // --------------------------------------------------------------
   // apb slave: zero wait states, read data captured in setup
   // --------------------------------------------------------------
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rd_val_q;

   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (paddr)
         OFS_PAUSE_FLOW_CONTROL: begin
            rd_val[QUANTA_LSB +: 16] = quanta_q;
            rd_val[HONOR_BIT] = honor_q;
            rd_val[BUSY_BIT] = busy_q;
         end
         OFS_STATS_CONTROL: begin
            rd_val[LIMIT_LSB +: LIMIT_W] = limit_q;
            rd_val[STATS_RSVD_BIT] = stats_rsvd_q;
         end
         OFS_LONG_FRAME_COUNT: rd_val = long_count_q;
         OFS_RESERVED_INIT_WORD_A: rd_val = rsvd_a_q;
         OFS_RESERVED_INIT_WORD_B: rd_val = rsvd_b_q;
         OFS_RX_FRAME_TOTAL_COUNT: rd_val = rx_count_q;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_val_q <= '0;
      end else if (setup) begin
         rd_val_q <= rd_val;
      end
   end

   // flow control word; the busy bit is owned by the pause sender below
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         quanta_q <= RST_QUANTA;
         honor_q <= RST_HONOR;
      end else if (wr_en && paddr == OFS_PAUSE_FLOW_CONTROL) begin
         if (pstrb[3:2] == 2'b11) begin
            quanta_q <= pwdata[QUANTA_LSB +: 16];
         end
         if (pstrb[0]) begin
            honor_q <= pwdata[HONOR_BIT];
         end
      end
   end

   // stats control and the two software-initialised words
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         limit_q <= RST_LIMIT;
         stats_rsvd_q <= RST_STATS_RSVD;
         rsvd_a_q <= RST_RESERVED_WORD;
         rsvd_b_q <= RST_RESERVED_WORD;
      end else if (wr_en) begin
         if (paddr == OFS_STATS_CONTROL && pstrb[1:0] == 2'b11) begin
            limit_q <= pwdata[LIMIT_LSB +: LIMIT_W];
            stats_rsvd_q <= pwdata[STATS_RSVD_BIT];
         end
         if (paddr == OFS_RESERVED_INIT_WORD_A) begin
            rsvd_a_q <= merge(rsvd_a_q, pwdata, pstrb);
         end
         if (paddr == OFS_RESERVED_INIT_WORD_B) begin
            rsvd_b_q <= merge(rsvd_b_q, pwdata, pstrb);
         end
      end
   end

   // --------------------------------------------------------------
   // receive statistics and pause honouring
   // --------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_count_q <= '0;
      end else if (rx_frame_done) begin
         rx_count_q <= rx_count_q + 32'h0000_0001; // wraps, no clear
      end
   end

   mps_pause_timer u_timer (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .load(rx_pause_valid && honor_q),
      .quanta(rx_pause_quanta),
      .hold(tx_paused)
   );

   // --------------------------------------------------------------
   // transmit path
   // --------------------------------------------------------------
   logic f_valid;
   logic f_ready;
   logic [8:0] f_data;
   mps_tx_state_t state_q;
   logic [5:0] idx_q;
   logic [15:0] sent_quanta_q;
   logic src_valid;
   logic src_ready;
   logic [7:0] src_data;
   logic src_last;
   logic src_fire;
   logic [15:0] len_q;

   mps_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(tx_in_valid),
      .in_ready(tx_in_ready),
      .in_data({tx_in_last, tx_in_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   function automatic logic [7:0] pause_byte(input logic [5:0] i, input logic [15:0] q);
      logic [7:0] b;
      b = 8'h00;
      if (i < 6'd6) begin
         b = PAUSE_DEST[8*(5 - i) +: 8];
      end else if (i < 6'd12) begin
         b = STATION_ADDR[8*(11 - i) +: 8];
      end else if (i == 6'd12) begin
         b = MAC_CTRL_TYPE[15:8];
      end else if (i == 6'd13) begin
         b = MAC_CTRL_TYPE[7:0];
      end else if (i == 6'd14) begin
         b = PAUSE_OPCODE[15:8];
      end else if (i == 6'd15) begin
         b = PAUSE_OPCODE[7:0];
      end else if (i == IDX_QUANTA_HI) begin
         b = q[15:8];
      end else if (i == IDX_QUANTA_HI + 6'd1) begin
         b = q[7:0];
      end
      return b;
   endfunction : pause_byte

   assign src_ready = !tx_out_valid || tx_out_ready;
   assign src_fire = src_valid && src_ready;
   assign f_ready = (state_q == TX_DATA) && src_ready;

   always_comb begin
      src_valid = 1'b0;
      src_data = 8'h00;
      src_last = 1'b0;
      unique case (state_q)
         TX_DATA: begin
            src_valid = f_valid;
            src_data = f_data[7:0];
            src_last = f_data[8];
         end
         TX_PAUSE: begin
            src_valid = 1'b1;
            src_data = pause_byte(idx_q, sent_quanta_q);
            src_last = (idx_q == PAUSE_FRAME_LEN - 6'd1);
         end
         default: begin
         end
      endcase
   end

   // frames start only at a boundary; a requested pause frame goes first
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= TX_IDLE;
         idx_q <= '0;
         sent_quanta_q <= '0;
      end else begin
         unique case (state_q)
            TX_IDLE: begin
               idx_q <= '0;
               if (busy_q) begin
                  state_q <= TX_PAUSE;
                  sent_quanta_q <= quanta_q;
               end else if (f_valid && !tx_paused) begin
                  state_q <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (src_fire && src_last) begin
                  state_q <= TX_IDLE;
               end
            end
            TX_PAUSE: begin
               if (src_fire) begin
                  idx_q <= idx_q + 6'd1;
                  if (src_last) begin
                     state_q <= TX_IDLE;
                  end
               end
            end
            default: state_q <= TX_IDLE;
         endcase
      end
   end

   // a new request written in the finishing cycle wins over the clear
   assign busy_done = (state_q == TX_PAUSE) && src_fire && src_last;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
      end else if (wr_en && paddr == OFS_PAUSE_FLOW_CONTROL && pstrb[0]
                   && pwdata[BUSY_BIT]) begin
         busy_q <= 1'b1;
      end else if (busy_done) begin
         busy_q <= 1'b0;
      end
   end

   // output register stage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_out_valid <= 1'b0;
         tx_out_data <= '0;
         tx_out_last <= 1'b0;
      end else if (src_ready) begin
         tx_out_valid <= src_valid;
         tx_out_data <= src_data;
         tx_out_last <= src_last;
      end
   end

   // length tally includes the last byte; limit compare in bytes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         len_q <= '0;
         long_count_q <= '0;
      end else if (src_fire) begin
         len_q <= src_last ? 16'h0000 : len_q + 16'h0001;
         if (src_last && (len_q + 16'h0001) > {5'h00, limit_q}) begin
            long_count_q <= long_count_q + 32'h0000_0001;
         end
      end
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   property p_quanta_byte;
      @(posedge clk_sys) disable iff (!rst_n)
         (state_q == TX_PAUSE && src_fire && idx_q == IDX_QUANTA_HI)
         |-> src_data == sent_quanta_q[15:8] ##1 src_data == sent_quanta_q[7:0];
   endproperty
   a_quanta_byte: assert property (p_quanta_byte)
      else $error("pause time field does not match programmed quanta");

   property p_honor;
      @(posedge clk_sys) disable iff (!rst_n)
         (rx_pause_valid && honor_q && rx_pause_quanta != 16'h0000)
         |-> ##1 tx_paused [*8];
   endproperty
   a_honor: assert property (p_honor)
      else $error("honoured pause frame did not hold the transmitter");

   property p_no_start_paused;
      @(posedge clk_sys) disable iff (!rst_n)
         (state_q == TX_IDLE && tx_paused && !busy_q) |=> state_q != TX_DATA;
   endproperty
   a_no_start_paused: assert property (p_no_start_paused)
      else $error("data frame started during received pause");

   property p_busy_set;
      @(posedge clk_sys) disable iff (!rst_n)
         (wr_en && paddr == OFS_PAUSE_FLOW_CONTROL && pstrb[0] && pwdata[BUSY_BIT])
         |=> busy_q ##[1:2] state_q == TX_PAUSE;
   endproperty
   a_busy_set: assert property (p_busy_set)
      else $error("pause request did not start a pause frame");

   property p_busy_clear;
      @(posedge clk_sys) disable iff (!rst_n)
         (busy_done && !wr_en) |=> !busy_q;
   endproperty
   a_busy_clear: assert property (p_busy_clear)
      else $error("busy not cleared after pause frame");

   property p_busy_held;
      @(posedge clk_sys) disable iff (!rst_n)
         (state_q == TX_PAUSE) |-> busy_q;
   endproperty
   a_busy_held: assert property (p_busy_held)
      else $error("busy dropped during pause frame");

   property p_limit_read;
      @(posedge clk_sys) disable iff (!rst_n)
         (setup && paddr == OFS_STATS_CONTROL) |=> prdata[13:3] == $past(limit_q);
   endproperty
   a_limit_read: assert property (p_limit_read)
      else $error("limit field not at bits 13 to 3");

   property p_long_count;
      @(posedge clk_sys) disable iff (!rst_n)
         (src_fire && src_last && len_q >= {5'h00, limit_q})
         |=> long_count_q == $past(long_count_q) + 32'h0000_0001;
   endproperty
   a_long_count: assert property (p_long_count)
      else $error("long frame not counted");

   property p_rx_read;
      @(posedge clk_sys) disable iff (!rst_n)
         (setup && paddr == OFS_RX_FRAME_TOTAL_COUNT) |=> prdata == $past(rx_count_q);
   endproperty
   a_rx_read: assert property (p_rx_read)
      else $error("receive counter not readable at its offset");

   property p_rx_count;
      @(posedge clk_sys) disable iff (!rst_n)
         1'b1 |=> rx_count_q == $past(rx_count_q) + {31'h0, $past(rx_frame_done)};
   endproperty
   a_rx_count: assert property (p_rx_count)
      else $error("receive counter step wrong");

   c_pause_sent: cover property (@(posedge clk_sys) disable iff (!rst_n) busy_done);
   c_long: cover property (@(posedge clk_sys) disable iff (!rst_n)
      src_fire && src_last && len_q >= {5'h00, limit_q});
   c_fifo_full: cover property (@(posedge clk_sys) disable iff (!rst_n) !tx_in_ready);
endmodule : mps_mac_ctrl

// file: logic/mps_pause_timer.sv
// received-pause hold timer counting 512-bit-time slots
`timescale 1ns/1ns
module mps_pause_timer
   import mps_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rst_n, // synchronised reset, active low
   input wire logic load, // honoured pause frame arrived
   input wire logic [15:0] quanta, // requested slots
   output logic hold // transmitter must wait
);
   localparam logic [10:0] SLOT_LAST = 11'(SLOT_CYCLES - 1);
   logic [15:0] slots_q;
   logic [10:0] tick_q;

   assign hold = (slots_q != 16'h0000);

   // a new pause frame restarts the wait, zero quanta releases at once
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slots_q <= '0;
         tick_q <= '0;
      end else if (load) begin
         slots_q <= quanta;
         tick_q <= '0;
      end else if (hold) begin
         if (tick_q == SLOT_LAST) begin
            tick_q <= '0;
            slots_q <= slots_q - 16'h0001;
         end else begin
            tick_q <= tick_q + 11'h001;
         end
      end
   end

   property p_slot_len;
      @(posedge clk_sys) disable iff (!rst_n)
         (hold && !load && tick_q == 11'h000) ##1 (!load)[*8] |-> tick_q == 11'h008;
   endproperty
   a_slot_len: assert property (p_slot_len)
      else $error("slot prescaler does not advance one per cycle");
endmodule : mps_pause_timer

// file: logic/mps_pkg.sv
// package: register map, field layout, reset values and timing for the pause/stats slice
package mps_pkg;
   // --------------------------------------------------------------
   // register byte offsets
   // --------------------------------------------------------------
   localparam logic [11:0] OFS_PAUSE_FLOW_CONTROL = 12'h01c;
   localparam logic [11:0] OFS_STATS_CONTROL = 12'h100;
   localparam logic [11:0] OFS_LONG_FRAME_COUNT = 12'h104;
   localparam logic [11:0] OFS_RESERVED_INIT_WORD_A = 12'h10c;
   localparam logic [11:0] OFS_RESERVED_INIT_WORD_B = 12'h110;
   localparam logic [11:0] OFS_RX_FRAME_TOTAL_COUNT = 12'h200;
   // --------------------------------------------------------------
   // fields
   // --------------------------------------------------------------
   localparam int QUANTA_LSB = 16;
   localparam int HONOR_BIT = 1;
   localparam int BUSY_BIT = 0;
   localparam int LIMIT_LSB = 3;
   localparam int LIMIT_W = 11;
   localparam int STATS_RSVD_BIT = 1;
   // --------------------------------------------------------------
   // reset values
   // --------------------------------------------------------------
   localparam logic [15:0] RST_QUANTA = 16'h0050;
   localparam logic RST_HONOR = 1'b1;
   localparam logic [10:0] RST_LIMIT = 11'h5ee;
   localparam logic RST_STATS_RSVD = 1'b1;
   localparam logic [31:0] RST_RESERVED_WORD = 32'h0000_0000;
   // --------------------------------------------------------------
   // pause frame layout
   // --------------------------------------------------------------
   localparam logic [47:0] PAUSE_DEST = 48'h0180_c200_0001;
   localparam logic [15:0] MAC_CTRL_TYPE = 16'h8808;
   localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
   localparam logic [5:0] PAUSE_FRAME_LEN = 6'h3c;
   localparam logic [5:0] IDX_QUANTA_HI = 6'h10;
   // --------------------------------------------------------------
   // timing: one pause slot is 512 bit times at 100 Mb/s
   // --------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int BIT_TIME_NS = 10;
   localparam int SLOT_BITS = 512;
   localparam int SLOT_CYCLES = SLOT_BITS * BIT_TIME_NS / CLK_PERIOD_NS;
   // --------------------------------------------------------------
   // transmit path states
   // --------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_DATA = 2'b01,
      TX_PAUSE = 2'b10
   } mps_tx_state_t;
endpackage : mps_pkg

// file: tb/mps_phy_model.sv
// phy-side sink that takes transmit bytes and can stall
`timescale 1ns/1ns
module mps_phy_model (
   input wire logic clk_sys, // system clock
   input wire logic stall, // hold ready low
   input wire logic tx_out_valid, // byte offered
   input wire logic [7:0] tx_out_data, // offered byte
   input wire logic tx_out_last, // frame end
   output logic tx_out_ready // byte accepted
);
   logic [7:0] rx_q[$];
   int frames = 0;
   initial tx_out_ready = 1'b0;
   // ready only moves after an edge, like a real mii shifter
   always @(posedge clk_sys) begin
      tx_out_ready <= !stall;
      if (tx_out_valid && tx_out_ready) begin
         rx_q.push_back(tx_out_data);
         // counted in the same step as the byte so bench reads agree
         if (tx_out_last) frames = frames + 1;
      end
   end
endmodule : mps_phy_model

// file: tb/testbench.sv
// self-checking bench for the pause and statistics slice
`timescale 1ns/1ns
module testbench
   import mps_pkg::*;
;
   logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, tx_in_ready, tx_out_valid, tx_out_ready, tx_out_last, tx_paused, er;
   logic tx_in_valid = 1'b0, tx_in_last = 1'b0, rx_frame_done = 1'b0, rx_pause_valid = 1'b0;
   logic stall = 1'b0;
   logic [7:0] tx_in_data = 8'h00, tx_out_data;
   logic [15:0] rx_pause_quanta = 16'h0000;
   int err_total = 0, checked = 0;
   always #2 clk_sys = ~clk_sys;
   mps_mac_ctrl uut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .tx_in_valid, .tx_in_ready, .tx_in_data, .tx_in_last,
      .tx_out_valid, .tx_out_ready, .tx_out_data, .tx_out_last, .rx_frame_done,
      .rx_pause_valid, .rx_pause_quanta, .tx_paused);
   mps_phy_model phy (.clk_sys, .stall, .tx_out_valid, .tx_out_data, .tx_out_last,
      .tx_out_ready);
   task automatic stop_test();
      if (err_total == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic hung(input int n, input int lim);
      if (n >= lim) begin
         chk(32'h0, 32'h1);
         stop_test();
      end
   endtask : hung
   // ----------------------------------------------------------------
   // bus and stream drivers
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      hung(n, 50);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   // stalls unstick after 20 refused cycles so the fill level is observable
   task automatic push(input int len, output int fill);
      int i, w;
      logic r;
      fill = 0;
      for (i = 0; i < len; i++) begin
         tx_in_valid <= 1'b1;
         tx_in_data <= i[7:0];
         tx_in_last <= (i == len - 1);
         w = 0;
         do begin
            @(negedge clk_sys);
            r = tx_in_ready;
            @(posedge clk_sys);
            w++;
            if (w == 20) begin
               fill = i;
               stall <= 1'b0;
            end
         end while (r !== 1'b1 && w < 300);
         hung(w, 300);
      end
      tx_in_valid <= 1'b0;
      tx_in_last <= 1'b0;
   endtask : push
   task automatic wait_rx(input int want);
      int n;
      for (n = 0; n < 500 && phy.rx_q.size() < want; n++) @(posedge clk_sys);
      hung(n, 500);
      chk(phy.rx_q.size(), want);
   endtask : wait_rx
   task automatic held(input int cyc, output int n);
      rx_pause_quanta <= 16'h0001;
      rx_pause_valid <= 1'b1;
      @(posedge clk_sys);
      rx_pause_valid <= 1'b0;
      n = 0;
      repeat (cyc) begin
         @(negedge clk_sys);
         if (tx_paused === 1'b1) n++;
      end
      @(posedge clk_sys);
   endtask : held
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      apb(0, OFS_PAUSE_FLOW_CONTROL, 0);
      chk(rd, {RST_QUANTA, 14'h0, RST_HONOR, 1'b0});
      apb(0, OFS_STATS_CONTROL, 0);
      chk(rd, {18'h0, RST_LIMIT, 1'b0, RST_STATS_RSVD, 1'b0});
      apb(1, OFS_RESERVED_INIT_WORD_A, 32'hffff_ffff);
      apb(1, OFS_RESERVED_INIT_WORD_B, 32'hffff_ffff);
      apb(0, OFS_RESERVED_INIT_WORD_A, 0);
      chk(rd, 32'hffff_ffff);
      apb(0, OFS_RESERVED_INIT_WORD_B, 0);
      chk(rd, 32'hffff_ffff);
      apb(0, 12'h3f0, 0);
      chk({31'h0, er}, 32'h1);
   endtask : t_regs
   task automatic t_pause();
      int n;
      apb(1, OFS_PAUSE_FLOW_CONTROL, 32'h1234_0003);
      apb(0, OFS_PAUSE_FLOW_CONTROL, 0);
      chk(rd, 32'h1234_0003);
      n = 0;
      do begin
         apb(0, OFS_PAUSE_FLOW_CONTROL, 0);
         n++;
      end while (rd[BUSY_BIT] !== 1'b0 && n < 100);
      hung(n, 100);
      wait_rx(PAUSE_FRAME_LEN);
      chk(phy.frames, 1);
      chk(phy.rx_q[0], 8'h01);
      chk(phy.rx_q[12], 8'h88);
      chk({phy.rx_q[16], phy.rx_q[17]}, 32'h1234);
   endtask : t_pause
   task automatic t_long();
      int fill;
      apb(1, OFS_STATS_CONTROL, {18'h0, 11'd39, 3'b010});
      stall <= 1'b1;
      push(40, fill);
      chk({31'h0, fill >= 32 && fill <= 35}, 32'h1);
      wait_rx(PAUSE_FRAME_LEN + 40);
      chk(phy.rx_q[PAUSE_FRAME_LEN + 39], 8'h27);
      push(39, fill);
      wait_rx(PAUSE_FRAME_LEN + 79);
      chk(phy.frames, 3);
      apb(0, OFS_LONG_FRAME_COUNT, 0);
      chk(rd, 32'h1);
   endtask : t_long
   task automatic t_rx();
      int n;
      apb(1, OFS_RX_FRAME_TOTAL_COUNT, 32'hffff_ffff);
      rx_frame_done <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rx_frame_done <= 1'b0;
      apb(0, OFS_RX_FRAME_TOTAL_COUNT, 0);
      chk(rd, 32'h3);
      nrst <= 1'b0;
      @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      apb(0, OFS_RX_FRAME_TOTAL_COUNT, 0);
      chk(rd, 32'h0);
      held(3000, n);
      chk(n, SLOT_CYCLES);
      apb(1, OFS_PAUSE_FLOW_CONTROL, 32'h1234_0000);
      held(100, n);
      chk(n, 0);
   endtask : t_rx
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_regs();
      t_pause();
      t_long();
      t_rx();
      stop_test();
   end
endmodule : testbench
